// >>> rtl/pfr_cfg.svh
// Purpose: constants for the power-fail reset and slow clock sequencer
// Assumes: 20 MHz crystal clock, asynchronous active-low reset, supply level from the comparator
// Notes: the rate codes, reset vector and settling and divider counts live here as macros
`ifndef PFR_CFG_SVH
`define PFR_CFG_SVH
`define PFR_STAB_CYCLES 17'h10000
`define PFR_CNT_W 17
`define PFR_RESET_VECTOR 16'h0000
`define PFR_RATE_RSVD 2'h0
`define PFR_RATE_DIV4 2'h1
`define PFR_RATE_DIV64 2'h2
`define PFR_RATE_DIV1024 2'h3
`define PFR_DIV4_LAST 10'h003
`define PFR_DIV64_LAST 10'h03F
`define PFR_DIV1024_LAST 10'h3FF
`endif

// >>> rtl/pfr_pkg.sv
// Purpose: types for the power-fail reset and slow clock sequencer
// Assumes: constants come from pfr_cfg.svh
// Notes: reset sequencer states are Gray coded along the power-up path
package pfr_pkg;
	typedef enum logic [1:0] {
		PFR_ST_HOLD = 2'h0,
		PFR_ST_STAB = 2'h1,
		PFR_ST_RUN = 2'h3
	} pfr_state_t;

	typedef struct packed {
		pfr_state_t state;
		logic [16:0] stab_cnt;
		logic sync1;
		logic sync2;
		logic rst_out_n;
		logic core_rst;
		logic osc_en;
		logic ram_wp;
		logic ram_on_backup;
		logic por_flag;
		logic [1:0] rate;
		logic [1:0] rate_pend;
		logic pend_valid;
		logic [9:0] div_cnt;
		logic cpu_tick;
		logic periph_tick;
		logic [9:0] idle_cnt;
		logic [15:0] start_addr;
	} pfr_state_s_t;
endpackage

// >>> rtl/pfr_top.sv
// Purpose: power-fail reset sequencing and machine-cycle rate divider
// Assumes: supply_low is a level from the comparator; firmware strobes are single cycles
// Notes: every output comes straight from a flip-flop of the state struct
`timescale 1ns/1ps
`include "pfr_cfg.svh"
module pfr_top (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Supply monitor and stop mode
	input wire logic supply_low,
	input wire logic stop_bandgap_off,
	// Firmware controls
	input wire logic rate_wr,
	input wire logic [1:0] rate_wdata,
	input wire logic auto_speed_restore_en,
	input wire logic por_flag_clr,
	input wire logic idle_mode,
	// Wake sources and serial activity
	input wire logic ext_irq_takeable,
	input wire logic serial_start_bit,
	input wire logic serial_rx_enable,
	input wire logic serial0_rx_activity,
	input wire logic serial0_tx_activity,
	// Reset and RAM protection outputs
	output logic reset_threshold_out_n,
	output logic core_reset,
	output logic osc_enable,
	output logic ram_write_protect,
	output logic ram_backup_power,
	output logic [15:0] core_start_addr,
	// Status and clocking outputs
	output logic por_flag,
	output logic [1:0] cycle_rate,
	output logic cpu_cycle_tick,
	output logic periph_cycle_tick
);
	pfr_pkg::pfr_state_s_t cur_ff;
	pfr_pkg::pfr_state_s_t nxt_ff;
	logic [9:0] div_last;
	logic restore_evt;
	logic rate_ok;

	// Divider terminal count for the active rate
	always_comb begin
		case (cur_ff.rate)
			`PFR_RATE_DIV64: div_last = `PFR_DIV64_LAST;
			`PFR_RATE_DIV1024: div_last = `PFR_DIV1024_LAST;
			default: div_last = `PFR_DIV4_LAST;
		endcase
	end

	// Hardware wake events may only speed the clock up, never slow it down
	assign restore_evt = auto_speed_restore_en &
		(ext_irq_takeable | (serial_start_bit & serial_rx_enable));
	// Slow codes only from /4, reserved code refused, blocked by serial activity
	assign rate_ok = rate_wr & ~serial0_rx_activity & ~serial0_tx_activity &
		(rate_wdata != `PFR_RATE_RSVD) &
		((rate_wdata == `PFR_RATE_DIV4) | (cur_ff.rate == `PFR_RATE_DIV4));

	// Next-state logic for the whole block
	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.sync1 = supply_low;
		nxt_ff.sync2 = cur_ff.sync1;
		case (cur_ff.state)
			pfr_pkg::PFR_ST_HOLD: begin
				nxt_ff.stab_cnt = '0;
				if (!cur_ff.sync2) begin
					nxt_ff.state = pfr_pkg::PFR_ST_STAB;
					nxt_ff.osc_en = 1'b1;
				end
			end
			pfr_pkg::PFR_ST_STAB: begin
				if (cur_ff.sync2) begin
					nxt_ff.state = pfr_pkg::PFR_ST_HOLD;
					nxt_ff.stab_cnt = '0;
				end else if (cur_ff.stab_cnt == `PFR_STAB_CYCLES - 17'h00001) begin
					nxt_ff.state = pfr_pkg::PFR_ST_RUN;
					nxt_ff.rst_out_n = 1'b1;
					nxt_ff.core_rst = 1'b0;
					nxt_ff.ram_wp = 1'b0;
					nxt_ff.start_addr = `PFR_RESET_VECTOR;
				end else begin
					nxt_ff.stab_cnt = cur_ff.stab_cnt + 17'h00001;
				end
			end
			pfr_pkg::PFR_ST_RUN: begin
				if (cur_ff.sync2) begin
					nxt_ff.state = pfr_pkg::PFR_ST_HOLD;
				end
			end
			default: nxt_ff.state = pfr_pkg::PFR_ST_HOLD;
		endcase
		// Any low-supply sample forces reset, pin low and RAM protection at once
		if (cur_ff.sync2) begin
			nxt_ff.core_rst = 1'b1;
			nxt_ff.rst_out_n = 1'b0;
			nxt_ff.ram_wp = 1'b1;
			nxt_ff.ram_on_backup = 1'b1;
		end else if (cur_ff.state == pfr_pkg::PFR_ST_RUN) begin
			nxt_ff.ram_wp = stop_bandgap_off;
			nxt_ff.ram_on_backup = stop_bandgap_off;
		end
		// Power-on flag: clear only by firmware, only the asynchronous reset sets it again
		if (por_flag_clr) begin
			nxt_ff.por_flag = 1'b0;
		end
		// A written rate applies at the next cycle boundary; reset and restore force /4 on the next edge and beat a write
		if (cur_ff.core_rst) begin
			nxt_ff.rate = `PFR_RATE_DIV4;
			nxt_ff.pend_valid = 1'b0;
		end else if (restore_evt) begin
			nxt_ff.rate = `PFR_RATE_DIV4;
			nxt_ff.pend_valid = 1'b0;
		end else if (rate_ok) begin
			nxt_ff.rate_pend = rate_wdata;
			nxt_ff.pend_valid = 1'b1;
		end
		// Machine-cycle divider
		nxt_ff.cpu_tick = 1'b0;
		if (cur_ff.core_rst || cur_ff.div_cnt >= div_last) begin
			nxt_ff.div_cnt = '0;
			nxt_ff.cpu_tick = ~cur_ff.core_rst & ~idle_mode;
			// A legal write landing on the boundary is the newest choice, so it is not lost behind the pending one
			if (cur_ff.pend_valid && !restore_evt && !cur_ff.core_rst) begin
				nxt_ff.rate = rate_ok ? rate_wdata : cur_ff.rate_pend;
				nxt_ff.pend_valid = 1'b0;
			end
		end else begin
			nxt_ff.div_cnt = cur_ff.div_cnt + 10'h001;
		end
		// Peripheral tick follows the CPU rate, but stays at /4 in idle
		nxt_ff.periph_tick = 1'b0;
		if (idle_mode) begin
			if (cur_ff.idle_cnt >= `PFR_DIV4_LAST) begin
				nxt_ff.idle_cnt = '0;
				nxt_ff.periph_tick = ~cur_ff.core_rst;
			end else begin
				nxt_ff.idle_cnt = cur_ff.idle_cnt + 10'h001;
			end
		end else begin
			nxt_ff.idle_cnt = '0;
			nxt_ff.periph_tick = nxt_ff.cpu_tick | (~cur_ff.core_rst & (cur_ff.div_cnt >= div_last) & idle_mode);
		end
	end

	// State register; reset is a power-on event so the flag is set
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cur_ff <= '0;
			cur_ff.state <= pfr_pkg::PFR_ST_HOLD;
			cur_ff.sync1 <= 1'b1;
			cur_ff.sync2 <= 1'b1;
			cur_ff.core_rst <= 1'b1;
			cur_ff.ram_wp <= 1'b1;
			cur_ff.ram_on_backup <= 1'b1;
			cur_ff.por_flag <= 1'b1;
			cur_ff.rate <= `PFR_RATE_DIV4;
			cur_ff.rate_pend <= `PFR_RATE_DIV4;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// Outputs straight from flip-flops
	assign reset_threshold_out_n = cur_ff.rst_out_n;
	assign core_reset = cur_ff.core_rst;
	assign osc_enable = cur_ff.osc_en;
	assign ram_write_protect = cur_ff.ram_wp;
	assign ram_backup_power = cur_ff.ram_on_backup;
	assign core_start_addr = cur_ff.start_addr;
	assign por_flag = cur_ff.por_flag;
	assign cycle_rate = cur_ff.rate;
	assign cpu_cycle_tick = cur_ff.cpu_tick;
	assign periph_cycle_tick = cur_ff.periph_tick;

	// Low supply seen by the synchroniser forces reset within one edge
	property p_hold_reset;
		@(posedge clk) disable iff (!resetn) cur_ff.sync2 |=> (core_reset && !reset_threshold_out_n);
	endproperty
	a_hold_reset: assert property (p_hold_reset) else $error("reset not held on low supply");

	// RAM protected while supply low
	property p_ram_wp;
		@(posedge clk) disable iff (!resetn) cur_ff.sync2 |=> ram_write_protect;
	endproperty
	a_ram_wp: assert property (p_ram_wp) else $error("RAM writable on low supply");

	// Release only from the final count value
	property p_release;
		@(posedge clk) disable iff (!resetn) $fell(core_reset) |->
			($past(cur_ff.stab_cnt) == 17'h0FFFF && reset_threshold_out_n && core_start_addr == 16'h0000);
	endproperty
	a_release: assert property (p_release) else $error("early reset release");

	// Supply drop during count returns to hold
	property p_abort;
		@(posedge clk) disable iff (!resetn)
			(cur_ff.state == pfr_pkg::PFR_ST_STAB && cur_ff.sync2) |=> (cur_ff.state == pfr_pkg::PFR_ST_HOLD && core_reset);
	endproperty
	a_abort: assert property (p_abort) else $error("count not abandoned");

	// Rate never changes straight between the two slow codes
	property p_no_slow_to_slow;
		@(posedge clk) disable iff (!resetn)
			(cycle_rate[1] && $past(cycle_rate[1])) |-> (cycle_rate == $past(cycle_rate));
	endproperty
	a_no_slow_to_slow: assert property (p_no_slow_to_slow) else $error("direct slow rate change");

	// Restore event forces the /4 rate on the next edge
	property p_restore;
		@(posedge clk) disable iff (!resetn) restore_evt |=> (cycle_rate == 2'h1);
	endproperty
	a_restore: assert property (p_restore) else $error("speed restore missed");

	// Serial activity blocks any rate write
	property p_serial_block;
		@(posedge clk) disable iff (!resetn)
			(rate_wr && (serial0_rx_activity || serial0_tx_activity) && !cur_ff.pend_valid)
			|=> !cur_ff.pend_valid;
	endproperty
	a_serial_block: assert property (p_serial_block) else $error("rate write not blocked");

	// At /4, ticks come every four clocks
	property p_div4;
		@(posedge clk) disable iff (!resetn)
			(cpu_cycle_tick && cycle_rate == 2'h1 && !idle_mode && !core_reset) |=> !cpu_cycle_tick [*3];
	endproperty
	a_div4: assert property (p_div4) else $error("divide by four spacing wrong");

	// Rate only ever moves to a slow code at a cycle boundary
	property p_entry_boundary;
		@(posedge clk) disable iff (!resetn) (cycle_rate[1] && !$past(cycle_rate[1])) |-> $past(cur_ff.div_cnt) >= 10'h003;
	endproperty
	a_entry_boundary: assert property (p_entry_boundary) else $error("rate changed mid cycle");

	// Oscillator must already run while the settling count is in progress
	property p_osc_in_count;
		@(posedge clk) disable iff (!resetn) (cur_ff.state == pfr_pkg::PFR_ST_STAB) |-> osc_enable;
	endproperty
	a_osc_in_count: assert property (p_osc_in_count) else $error("count without oscillator");

	// Settling count advances by one per clock while the supply stays good
	property p_count_step;
		@(posedge clk) disable iff (!resetn) (cur_ff.state == pfr_pkg::PFR_ST_STAB && !cur_ff.sync2 &&
			cur_ff.stab_cnt != (`PFR_STAB_CYCLES - 17'h00001)) |=> (cur_ff.stab_cnt == $past(cur_ff.stab_cnt) + 17'h00001);
	endproperty
	a_count_step: assert property (p_count_step) else $error("settling count skipped");

	// Until the run state the pin stays low and the core stays in reset
	property p_held_until_run;
		@(posedge clk) disable iff (!resetn) (cur_ff.state != pfr_pkg::PFR_ST_RUN) |-> (core_reset && !reset_threshold_out_n);
	endproperty
	a_held_until_run: assert property (p_held_until_run) else $error("reset released before run");

	// Only a power-on reset may raise the flag again
	property p_por_no_set;
		@(posedge clk) disable iff (!resetn) !por_flag |=> !por_flag;
	endproperty
	a_por_no_set: assert property (p_por_no_set) else $error("power-on flag set without reset");

	// Flag holds until firmware clears it
	property p_por_keep;
		@(posedge clk) disable iff (!resetn) (por_flag && !por_flag_clr) |=> por_flag;
	endproperty
	a_por_keep: assert property (p_por_keep) else $error("power-on flag lost");

	// CPU ticks stop in idle
	property p_idle_cpu_stop;
		@(posedge clk) disable iff (!resetn) idle_mode |=> !cpu_cycle_tick;
	endproperty
	a_idle_cpu_stop: assert property (p_idle_cpu_stop) else $error("cpu tick in idle");

	// Outside idle the peripheral tick is the CPU tick
	property p_periph_follow;
		@(posedge clk) disable iff (!resetn) !idle_mode |=> (periph_cycle_tick == cpu_cycle_tick);
	endproperty
	a_periph_follow: assert property (p_periph_follow) else $error("peripheral tick off cpu rate");

	// Stop with bandgap off protects the RAM and moves it to backup power
	property p_stop_protect;
		@(posedge clk) disable iff (!resetn)
			(cur_ff.state == pfr_pkg::PFR_ST_RUN && stop_bandgap_off) |=> (ram_write_protect && ram_backup_power);
	endproperty
	a_stop_protect: assert property (p_stop_protect) else $error("RAM unprotected in stop");

	// Reserved code never becomes pending
	property p_rsvd_refused;
		@(posedge clk) disable iff (!resetn)
			(rate_wr && rate_wdata == `PFR_RATE_RSVD && !cur_ff.pend_valid) |=> !cur_ff.pend_valid;
	endproperty
	a_rsvd_refused: assert property (p_rsvd_refused) else $error("reserved rate accepted");

	// Without a pending firmware write nothing can slow the clock
	property p_no_hw_slow;
		@(posedge clk) disable iff (!resetn) (!cycle_rate[1] && !cur_ff.pend_valid) |=> !cycle_rate[1];
	endproperty
	a_no_hw_slow: assert property (p_no_hw_slow) else $error("slow rate without write");

	// A machine-cycle tick is a single-clock pulse
	property p_tick_single;
		@(posedge clk) disable iff (!resetn) cpu_cycle_tick |=> !cpu_cycle_tick;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("tick longer than one clock");

	// Second stage always copies the first, so the level is seen two edges late
	property p_sync_chain;
		@(posedge clk) disable iff (!resetn) 1'b1 |=> (cur_ff.sync2 == $past(cur_ff.sync1));
	endproperty
	a_sync_chain: assert property (p_sync_chain) else $error("supply synchroniser broken");
endmodule

// >>> test/pfr_board.sv
// Purpose: board side model, supply comparator and system reset net
// Assumes: supply_ok is the bench's view of the supply rail
// Notes: comparator output is a plain level, no hysteresis modelled
`timescale 1ns/1ps
module pfr_board (
	// Rail control from the bench
	input wire logic supply_ok,
	// Reset-out pin from the device
	input wire logic reset_threshold_out_n,
	// Comparator level and board reset net
	output logic supply_low,
	output logic board_reset_n
);
	// Comparator flags the rail low whenever it is not good
	assign supply_low = ~supply_ok;
	// Rest of the board is held in reset by the pin, it never overrides it
	assign board_reset_n = reset_threshold_out_n;
endmodule

// >>> test/pfr_top_test.sv
// Purpose: self-checking bench for the power-fail reset and rate divider
// Assumes: 50 ns clock, inputs change 5 ns after the rising edge
// Notes: one full stabilisation count is run, so the run is long by nature
`timescale 1ns/1ps
module pfr_top_test;
	// Clock, reset and stimulus
	logic clk = 1'b0, resetn = 1'b0, supply_ok = 1'b0, stop_bandgap_off = 1'b0;
	logic rate_wr = 1'b0, auto_speed_restore_en = 1'b0, por_flag_clr = 1'b0, idle_mode = 1'b0;
	logic ext_irq_takeable = 1'b0, serial_start_bit = 1'b0, serial_rx_enable = 1'b0;
	logic serial0_rx_activity = 1'b0, serial0_tx_activity = 1'b0;
	logic [1:0] rate_wdata = 2'h1;
	// Observed outputs
	logic supply_low, board_reset_n, reset_threshold_out_n, core_reset, osc_enable;
	logic ram_write_protect, ram_backup_power, por_flag, cpu_cycle_tick, periph_cycle_tick, seen;
	logic [15:0] core_start_addr;
	logic [1:0] cycle_rate;
	int n_fail = 0, checks_done = 0, cyc = 0, n;
	always #25 clk = ~clk;
	pfr_board board (.supply_ok(supply_ok), .reset_threshold_out_n(reset_threshold_out_n),
		.supply_low(supply_low), .board_reset_n(board_reset_n));
	pfr_top uut (.clk(clk), .resetn(resetn), .supply_low(supply_low), .stop_bandgap_off(stop_bandgap_off),
		.rate_wr(rate_wr), .rate_wdata(rate_wdata), .auto_speed_restore_en(auto_speed_restore_en),
		.por_flag_clr(por_flag_clr), .idle_mode(idle_mode), .ext_irq_takeable(ext_irq_takeable),
		.serial_start_bit(serial_start_bit), .serial_rx_enable(serial_rx_enable),
		.serial0_rx_activity(serial0_rx_activity), .serial0_tx_activity(serial0_tx_activity),
		.reset_threshold_out_n(reset_threshold_out_n), .core_reset(core_reset), .osc_enable(osc_enable),
		.ram_write_protect(ram_write_protect), .ram_backup_power(ram_backup_power),
		.core_start_addr(core_start_addr), .por_flag(por_flag), .cycle_rate(cycle_rate),
		.cpu_cycle_tick(cpu_cycle_tick), .periph_cycle_tick(periph_cycle_tick));
	// Closing report, reached from the main sequence or the hang guard
	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Compare one observed value with its expectation
	task chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("BAD %s expected %0h seen %0h", nm, exp, got);
			n_fail++;
		end
	endtask
	// Advance to just after a rising edge
	task step(input int k = 1);
		repeat (k) begin
			@(posedge clk);
			#5;
		end
	endtask
	// Gap between two machine-cycle ticks, bounded past the slowest rate
	task tick_gap(input bit per, output int g);
		int i;
		i = 0;
		while (((per ? periph_cycle_tick : cpu_cycle_tick) !== 1'b1) && i < 2100) begin
			step();
			i++;
		end
		g = 0;
		do begin
			step();
			g++;
		end while (((per ? periph_cycle_tick : cpu_cycle_tick) !== 1'b1) && g < 2100);
	endtask
	// Firmware rate write; the longest machine cycle bounds when it lands
	task set_rate(input logic [1:0] c);
		rate_wdata = c;
		rate_wr = 1'b1;
		step();
		rate_wr = 1'b0;
		step(1100);
	endtask
	// Guard against a hang: the whole sequence needs about 80k cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 95000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		step(12);
		chk("core_reset", 1, core_reset);
		chk("rst_out_n", 0, board_reset_n);
		chk("ram_wp", 1, ram_write_protect);
		chk("por_flag", 1, por_flag);
		chk("rate", 2'h1, cycle_rate);
		chk("osc_en", 0, osc_enable);
		resetn = 1'b1;
		supply_ok = 1'b1;
		step(500);
		chk("core_reset_early", 1, core_reset);
		supply_ok = 1'b0;
		step(10);
		chk("core_reset_drop", 1, core_reset);
		supply_ok = 1'b1;
		n = 0;
		while (core_reset !== 1'b0 && n < 70000) begin
			step();
			n++;
		end
		chk("stab_len_ok", 1, n inside {[65536:65542]});
		chk("rst_out_n_up", 1, board_reset_n);
		chk("ram_wp_off", 0, ram_write_protect);
		chk("start_addr", 16'h0000, core_start_addr);
		chk("osc_en_up", 1, osc_enable);
		chk("por_kept", 1, por_flag);
		por_flag_clr = 1'b1;
		step();
		por_flag_clr = 1'b0;
		step(2);
		chk("por_cleared", 0, por_flag);
		chk("backup_off", 0, ram_backup_power);
		tick_gap(0, n);
		chk("gap4", 4, n);
		set_rate(2'h0);
		chk("rate_rsvd", 2'h1, cycle_rate);
		set_rate(2'h2);
		chk("rate64", 2'h2, cycle_rate);
		tick_gap(0, n);
		chk("gap64", 64, n);
		ext_irq_takeable = 1'b1;
		step();
		ext_irq_takeable = 1'b0;
		step(4);
		chk("no_hw_change", 2'h2, cycle_rate);
		set_rate(2'h3);
		chk("slow_to_slow", 2'h2, cycle_rate);
		auto_speed_restore_en = 1'b1;
		ext_irq_takeable = 1'b1;
		step();
		ext_irq_takeable = 1'b0;
		step(4);
		chk("irq_restore", 2'h1, cycle_rate);
		set_rate(2'h3);
		chk("rate1024", 2'h3, cycle_rate);
		tick_gap(0, n);
		chk("gap1024", 1024, n);
		set_rate(2'h1);
		chk("back4", 2'h1, cycle_rate);
		set_rate(2'h2);
		serial_start_bit = 1'b1;
		step();
		serial_start_bit = 1'b0;
		step(4);
		chk("start_no_rx", 2'h2, cycle_rate);
		serial_rx_enable = 1'b1;
		serial_start_bit = 1'b1;
		step();
		serial_start_bit = 1'b0;
		step(4);
		chk("start_restore", 2'h1, cycle_rate);
		serial0_rx_activity = 1'b1;
		set_rate(2'h2);
		chk("rx_blocks", 2'h1, cycle_rate);
		serial0_rx_activity = 1'b0;
		serial0_tx_activity = 1'b1;
		set_rate(2'h3);
		chk("tx_blocks", 2'h1, cycle_rate);
		serial0_tx_activity = 1'b0;
		idle_mode = 1'b1;
		step(2);
		seen = 1'b0;
		repeat (20) begin
			step();
			seen = seen | cpu_cycle_tick;
		end
		chk("idle_cpu", 0, seen);
		tick_gap(1, n);
		chk("idle_gap4", 4, n);
		idle_mode = 1'b0;
		stop_bandgap_off = 1'b1;
		step(3);
		chk("stop_wp", 1, ram_write_protect);
		chk("stop_backup", 1, ram_backup_power);
		stop_bandgap_off = 1'b0;
		step(2);
		chk("stop_exit_wp", 0, ram_write_protect);
		supply_ok = 1'b0;
		step(4);
		chk("fail_core", 1, core_reset);
		chk("fail_rst_out", 0, board_reset_n);
		chk("fail_wp", 1, ram_write_protect);
		end_of_test();
	end
endmodule
